// ### hw/byte_fifo.v
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Output data come from a register stage, so capacity is DEPTH + 1
`timescale 1ns/1ps

module byte_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      cnt_q;
  reg             out_valid_q;
  reg [WIDTH-1:0] out_data_q;
  wire            push;
  wire            pop_mem;

  // ==========================================================================
  // Handshakes
  // ==========================================================================
  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign push      = in_valid & in_ready;
  // Refill the output stage whenever it is empty or being drained
  assign pop_mem   = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);
  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;

  // Storage array, written without reset
  always @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers, fill level and output register
  always @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr_q    <= {AW{1'b0}};
      rd_ptr_q    <= {AW{1'b0}};
      cnt_q       <= {(AW+1){1'b0}};
      out_valid_q <= 1'b0;
      out_data_q  <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop_mem)
      begin
        rd_ptr_q    <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
        out_data_q  <= mem_q[rd_ptr_q];
        out_valid_q <= 1'b1;
      end
      else if (out_ready)
      begin
        out_valid_q <= 1'b0;
      end
      case ({push, pop_mem})
        2'b10:   cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
        2'b01:   cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
        default: cnt_q <= cnt_q;
      endcase
    end
  end

endmodule

// ### hw/mgmt_slave_defines.vh
// Purpose: Shared constants of the two-wire management slave
// Assumes: Included by bare name from every design file that needs it
// Notes:   Definitions only, no logic
`ifndef MGMT_SLAVE_DEFINES_VH
`define MGMT_SLAVE_DEFINES_VH

// ==========================================================================
// Bus addressing
// ==========================================================================
`define DEV_ADDR        7'h50
`define MAP_FLAG_ADDR   8'h80
`define MAP_FLAG_VALUE  8'h01
`define ADDR_RESET      8'h00

// ==========================================================================
// Byte framing
// ==========================================================================
`define BITS_PER_BYTE   4'h8
`define BIT_CNT_RESET   4'h0

// ==========================================================================
// Byte kinds expected by the receiver
// ==========================================================================
`define KIND_DEV        2'h0
`define KIND_MEM        2'h1
`define KIND_DATA       2'h2

// ==========================================================================
// Write FIFO shape
// ==========================================================================
`define WFIFO_WIDTH     16
`define WFIFO_DEPTH     8
`define WFIFO_AW        3

`endif

// ### hw/module_mgmt_i2c_slave.v
// Purpose: Two-wire management slave of a pluggable loopback test module
// Assumes: clk at 20 MHz oversamples the host serial clock (max 400 kHz)
// Notes:   Serial pins are sampled through two flip-flops; the data pin is
//          open-drain, only ever pulled low; write bytes leave via a FIFO
`timescale 1ns/1ps
`include "mgmt_slave_defines.vh"

// Overview of operation
// - Green LED on while module selected
// - Amber LED on while low-power select low
// - Address 128 reports newer memory map
// - Answer fixed device address A0h
// - Deselected: no acknowledge, no action
// - Ignore bus unless module select low
// - Sample on clock rise, drive after fall
// - Slave only; host clocks every transfer
// - Data line driven low or released only
// - Data changes only while clock low
// - Bytes are eight bits, MSB first
// - START is data falling, clock high
// - STOP is data rising, ends transfer
// - Transmitter releases line for acknowledge
// - Acknowledge address and write bytes (write bytes refused while the write FIFO is full)
// - Recovery resets only interface state machine
// - First byte is address, LSB read
// - Matching address selected: pull low for ack
// - Address counter wraps within 128-byte page
// - Repeated START keeps loaded byte address
// - Keep sending read bytes while acked
// - Low-power select high means low power
module module_mgmt_i2c_slave (
  input  wire       clk,
  input  wire       rst,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe,
  input  wire       module_select_n,
  input  wire       low_power_select,
  output wire       green_led,
  output wire       amber_led,
  output wire       high_power_mode,
  output wire [7:0] rd_addr,
  input  wire [7:0] rd_data,
  output wire       wr_valid,
  input  wire       wr_ready,
  output wire [7:0] wr_addr,
  output wire [7:0] wr_data
);

  // ==========================================================================
  // States, one-hot
  // ==========================================================================
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_RX   = 6'h02;
  localparam [5:0] ST_ACK  = 6'h04;
  localparam [5:0] ST_TX   = 6'h08;
  localparam [5:0] ST_RACK = 6'h10;
  localparam [5:0] ST_IGN  = 6'h20;

  // Synchronisers and edge history
  reg        scl_m_q;
  reg        scl_s_q;
  reg        scl_p_q;
  reg        sda_m_q;
  reg        sda_s_q;
  reg        sda_p_q;
  reg        sel_m_q;
  reg        sel_n_q;
  reg        lp_m_q;
  reg        lp_s_q;

  // Protocol engine
  reg [5:0]  state_q;
  reg [3:0]  bit_cnt_q;
  reg [7:0]  shreg_q;
  reg [1:0]  kind_q;
  reg        read_q;
  reg        ack_q;
  reg        more_q;
  reg [7:0]  addr_q;
  reg        pull_q;
  reg        push_q;
  reg [15:0] push_word_q;

  wire       scl_rise;
  wire       scl_fall;
  wire       start_det;
  wire       stop_det;
  wire       selected;
  wire [7:0] tx_byte;
  wire [7:0] addr_next;
  wire       fifo_in_ready;
  wire [15:0] fifo_out;

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  // Two flops per pin; the third serial flop only keeps edge history
  always @(posedge clk)
  begin
    if (rst)
    begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      sel_m_q <= 1'b1;
      sel_n_q <= 1'b1;
      lp_m_q  <= 1'b1;
      lp_s_q  <= 1'b1;
    end
    else
    begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      sel_m_q <= module_select_n;
      sel_n_q <= sel_m_q;
      lp_m_q  <= low_power_select;
      lp_s_q  <= lp_m_q;
    end
  end

  // ==========================================================================
  // Low-speed indicators
  // ==========================================================================
  // Reset values read as deselected and low power, like the pull-ups
  assign green_led       = ~sel_n_q;
  assign amber_led       = ~lp_s_q;
  assign high_power_mode = ~lp_s_q;
  assign selected        = ~sel_n_q;

  // ==========================================================================
  // Bus event detection
  // ==========================================================================
  // Host owns the clock; we only ever watch it
  assign scl_rise  = scl_s_q & ~scl_p_q;
  assign scl_fall  = ~scl_s_q & scl_p_q;
  // Data moving while the clock stays high marks framing
  assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // Byte counter wraps inside the current 128-byte page
  assign addr_next = {addr_q[7], addr_q[6:0] + 7'h01};
  // The map-revision byte is answered locally, everything else by the user
  assign tx_byte   = (addr_q == `MAP_FLAG_ADDR) ? `MAP_FLAG_VALUE : rd_data;
  assign rd_addr   = addr_q;

  // Open drain: the output level is always low, only the enable moves
  assign sda_o     = 1'b0;
  assign sda_oe    = pull_q;

  // ==========================================================================
  // Protocol state machine
  // ==========================================================================
  // START and STOP take priority over every state; they also serve as the
  // bus-recovery reset and touch nothing but this engine
  always @(posedge clk)
  begin
    if (rst)
    begin
      state_q     <= ST_IDLE;
      bit_cnt_q   <= `BIT_CNT_RESET;
      shreg_q     <= 8'h00;
      kind_q      <= `KIND_DEV;
      read_q      <= 1'b0;
      ack_q       <= 1'b0;
      more_q      <= 1'b0;
      addr_q      <= `ADDR_RESET;
      pull_q      <= 1'b0;
      push_q      <= 1'b0;
      push_word_q <= 16'h0000;
    end
    else
    begin
      push_q <= 1'b0;
      if (start_det)
      begin
        // A repeated START leaves addr_q untouched
        pull_q    <= 1'b0;
        bit_cnt_q <= `BIT_CNT_RESET;
        kind_q    <= `KIND_DEV;
        state_q   <= selected ? ST_RX : ST_IGN;
      end
      else if (stop_det)
      begin
        pull_q  <= 1'b0;
        state_q <= ST_IDLE;
      end
      else if (!selected && (state_q != ST_IDLE))
      begin
        // Deselect mid-transfer: let go of the line at once
        pull_q  <= 1'b0;
        state_q <= ST_IGN;
      end
      else
      begin
        case (state_q)
          ST_RX:
          begin
            if (scl_rise)
            begin
              shreg_q   <= {shreg_q[6:0], sda_s_q};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else if (scl_fall && (bit_cnt_q == `BITS_PER_BYTE))
            begin
              bit_cnt_q <= `BIT_CNT_RESET;
              state_q   <= ST_ACK;
              case (kind_q)
                `KIND_DEV:
                begin
                  read_q <= shreg_q[0];
                  ack_q  <= (shreg_q[7:1] == `DEV_ADDR);
                  pull_q <= (shreg_q[7:1] == `DEV_ADDR);
                  kind_q <= `KIND_MEM;
                end
                `KIND_MEM:
                begin
                  addr_q <= shreg_q;
                  ack_q  <= 1'b1;
                  pull_q <= 1'b1;
                  kind_q <= `KIND_DATA;
                end
                default:
                begin
                  // A full FIFO cannot take the byte, so it is refused
                  ack_q <= fifo_in_ready;
                  pull_q <= fifo_in_ready;
                  if (fifo_in_ready)
                  begin
                    push_q      <= 1'b1;
                    push_word_q <= {addr_q, shreg_q};
                    addr_q      <= addr_next;
                  end
                end
              endcase
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              if (!ack_q)
              begin
                pull_q  <= 1'b0;
                state_q <= ST_IGN;
              end
              else if (read_q && (kind_q == `KIND_MEM))
              begin
                // Read after address ack: first bit goes out now
                shreg_q <= tx_byte;
                pull_q  <= ~tx_byte[7];
                state_q <= ST_TX;
              end
              else
              begin
                pull_q  <= 1'b0;
                state_q <= ST_RX;
              end
            end
          end
          ST_TX:
          begin
            if (scl_rise)
            begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else if (scl_fall)
            begin
              if (bit_cnt_q == `BITS_PER_BYTE)
              begin
                // Hand the line to the host for its acknowledge
                pull_q    <= 1'b0;
                bit_cnt_q <= `BIT_CNT_RESET;
                addr_q    <= addr_next;
                state_q   <= ST_RACK;
              end
              else
              begin
                shreg_q <= {shreg_q[6:0], 1'b0};
                pull_q  <= ~shreg_q[6];
              end
            end
          end
          ST_RACK:
          begin
            if (scl_rise)
            begin
              more_q <= ~sda_s_q;
            end
            else if (scl_fall)
            begin
              if (more_q)
              begin
                shreg_q <= tx_byte;
                pull_q  <= ~tx_byte[7];
                state_q <= ST_TX;
              end
              else
              begin
                state_q <= ST_IGN;
              end
            end
          end
          ST_IGN:
          begin
            pull_q <= 1'b0;
          end
          ST_IDLE:
          begin
            pull_q <= 1'b0;
          end
          default:
          begin
            pull_q  <= 1'b0;
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Write data path
  // ==========================================================================
  // Back-pressure shows on the bus as a refused byte, since the slave
  // cannot stretch the host clock
  byte_fifo #(
    .WIDTH (`WFIFO_WIDTH),
    .DEPTH (`WFIFO_DEPTH),
    .AW    (`WFIFO_AW)
  ) u_wfifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push_q),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word_q),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (fifo_out)
  );

  assign wr_addr = fifo_out[15:8];
  assign wr_data = fifo_out[7:0];

endmodule

// ### tb/i2c_host.sv
// Purpose: Host bus master model for the slave's serial port
// Assumes: Bench makes the open-drain wire with a pull-up
// Notes:   Clock stands high between frames; low 250 ns, high 150 ns
`timescale 1ns/1ps

module i2c_host (
  output reg  scl,
  output reg  sda_rel,
  input  wire sda
);
  // ==================
  // Bus cycles
  // ==================
  // Idle: both lines released
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // One clock; data set mid-low, sampled mid-high
  task bit_cyc(input reg d, output reg s);
  begin
    scl = 1'b0;
    #100 sda_rel = d;
    #150 scl = 1'b1;
    #75 s = sda;
    #75;
  end
  endtask

  // START (v = 0) or STOP (v = 1); long tail lets the slave see it
  task cond(input reg v);
  begin
    scl = 1'b0;
    #100 sda_rel = ~v;
    #150 scl = 1'b1;
    #50 sda_rel = v;
    #200;
  end
  endtask

  // Byte MSB first, then ninth bit r (1 releases); ack is 1 if seen low
  task xfer(input reg [7:0] d, input reg r, output reg [7:0] q, output reg ack);
    integer i;
    reg     s;
  begin
    for (i = 7; i >= 0; i = i - 1)
    begin
      bit_cyc(d[i], s);
      q[i] = s;
    end
    bit_cyc(r, s);
    ack = ~s;
  end
  endtask

  // Clock until the line reads high, at most nine times, then START
  task recover;
    integer i;
    reg     s;
  begin
    s = 1'b0;
    for (i = 0; i < 9 && s !== 1'b1; i = i + 1)
      bit_cyc(1'b1, s);
    cond(1'b0);
  end
  endtask
endmodule

// ### tb/mgmt_slave_properties.sv
// Purpose: Port assertions of the management slave
// Assumes: Pin inputs settle through two clocks of sync
// Notes:   Bound to every slave instance
`timescale 1ns/1ps

module mgmt_slave_checker (
  input wire       clk,
  input wire       rst,
  input wire       scl_i,
  input wire       sda_o,
  input wire       sda_oe,
  input wire       module_select_n,
  input wire       low_power_select,
  input wire       green_led,
  input wire       amber_led,
  input wire       high_power_mode,
  input wire       wr_valid,
  input wire       wr_ready,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data
);
  // ==================
  // Assertions
  // ==================
  // Five quiet cycles cover the two-flop sync pipe; the LEDs come straight from it
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  green_follow_a: assert property (
    !$changed(module_select_n) [*5] |-> green_led == !module_select_n)
    else $error("green LED wrong");
  amber_follow_a: assert property (
    !$changed(low_power_select) [*5] |-> amber_led == !low_power_select && high_power_mode == amber_led)
    else $error("amber LED or power mode wrong");
  drive_low_a: assert property (
    sda_oe |-> sda_o == 1'b0)
    else $error("data pin driven high");
  deselect_quiet_a: assert property (
    module_select_n [*5] |-> !sda_oe)
    else $error("drives while deselected");
  change_low_a: assert property (
    $changed(sda_oe) |-> !scl_i)
    else $error("data moved with clock high");
  after_fall_a: assert property (
    $changed(sda_oe) |-> !$past(scl_i, 2))
    else $error("data moved not after clock fall");
  idle_release_a: assert property (
    scl_i [*8] |-> !sda_oe)
    else $error("line held while bus idle");
  write_hold_a: assert property (
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
    else $error("write word lost before taken");
endmodule

bind module_mgmt_i2c_slave mgmt_slave_checker mgmt_slave_checker_i (
  .clk              (clk),
  .rst              (rst),
  .scl_i            (scl_i),
  .sda_o            (sda_o),
  .sda_oe           (sda_oe),
  .module_select_n  (module_select_n),
  .low_power_select (low_power_select),
  .green_led        (green_led),
  .amber_led        (amber_led),
  .high_power_mode  (high_power_mode),
  .wr_valid         (wr_valid),
  .wr_ready         (wr_ready),
  .wr_addr          (wr_addr),
  .wr_data          (wr_data)
);

// ### tb/module_mgmt_i2c_slave_tb_top.sv
// Purpose: Self-checking bench of the management slave
// Assumes: Pull-up on the data wire; read data follow an address pattern
// Notes:   Write port is stalled so the FIFO fills and refuses
`timescale 1ns/1ps

module module_mgmt_i2c_slave_tb_top;
  reg        clk, rst, module_select_n, low_power_select, wr_ready, ack;
  reg  [7:0] b;
  integer    miscompares, checks, i, j;
  wire       scl, sda_rel, sda_o, sda_oe, green_led, amber_led, high_power_mode, wr_valid;
  wire [7:0] rd_addr, wr_addr, wr_data;
  // Open-drain wire: low if either party pulls
  wire       sda = sda_rel & ~(sda_oe & ~sda_o);
  // Pattern memory behind the read port
  wire [7:0] rd_data = rd_addr ^ 8'h3C;

  module_mgmt_i2c_slave module_mgmt_i2c_slave_i (
    .clk              (clk),
    .rst              (rst),
    .scl_i            (scl),
    .sda_i            (sda),
    .sda_o            (sda_o),
    .sda_oe           (sda_oe),
    .module_select_n  (module_select_n),
    .low_power_select (low_power_select),
    .green_led        (green_led),
    .amber_led        (amber_led),
    .high_power_mode  (high_power_mode),
    .rd_addr          (rd_addr),
    .rd_data          (rd_data),
    .wr_valid         (wr_valid),
    .wr_ready         (wr_ready),
    .wr_addr          (wr_addr),
    .wr_data          (wr_data)
  );
  i2c_host i2c_host_i (
    .scl     (scl),
    .sda_rel (sda_rel),
    .sda     (sda)
  );

  // ==================
  // Clock and helpers
  // ==================
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Inputs move 5 ns after the edge
  task cyc(input integer n);
  begin
    repeat (n) @(posedge clk);
    #5;
  end
  endtask

  task chk(input string name, input [7:0] exp, input [7:0] got);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  end
  endtask

  task chk1(input string name, input e, input g);
  begin
    chk(name, {7'h00, e}, {7'h00, g});
  end
  endtask

  task tx(input [7:0] d);
  begin
    i2c_host_i.xfer(d, 1'b1, b, ack);
  end
  endtask

  // Select set up before and held after the whole frame
  task sel(input v);
  begin
    cyc(1);
    module_select_n = v;
    cyc(4);
  end
  endtask

  // Dummy write of the byte address, repeated START, read n bytes
  task rd_seq(input [7:0] a, input integer n);
    integer   k;
    reg [7:0] e;
  begin
    sel(1'b0);
    i2c_host_i.cond(1'b0);
    tx(8'hA0);
    tx(a);
    i2c_host_i.cond(1'b0);
    tx(8'hA1);
    chk1("rd_dev_ack", 1'b1, ack);
    for (k = 0; k < n; k = k + 1)
    begin
      i2c_host_i.xfer(8'hFF, k == n - 1, b, ack);
      e = {a[7], a[6:0] + k[6:0]};
      chk("rd_byte", (e == 8'h80) ? 8'h01 : e ^ 8'h3C, b);
    end
    i2c_host_i.cond(1'b1);
    sel(1'b1);
  end
  endtask

  task stop_test;
  begin
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  // Tests need about 110 us; over five times that means a hang
  initial
  begin
    #600000;
    miscompares = miscompares + 1;
    stop_test;
  end

  // ==================
  // Tests
  // ==================
  initial
  begin
    rst = 1'b1;
    module_select_n = 1'b1;
    low_power_select = 1'b1;
    wr_ready = 1'b0;
    miscompares = 0;
    checks = 0;
    cyc(8);
    rst = 1'b0;
    cyc(4);
    chk1("rst_valid", 1'b0, wr_valid);
    // Every select and power combination
    for (i = 0; i < 4; i = i + 1)
    begin
      {module_select_n, low_power_select} = i[1:0];
      cyc(6);
      chk1("green", ~module_select_n, green_led);
      chk1("amber", ~low_power_select, amber_led);
      chk1("hp_mode", ~low_power_select, high_power_mode);
    end
    $display("test leds done");
    low_power_select = 1'b0;
    // Ten bytes into a stalled port: nine fit, the tenth is refused
    sel(1'b0);
    i2c_host_i.cond(1'b0);
    tx(8'hA0);
    chk1("wr_dev_ack", 1'b1, ack);
    tx(8'h7E);
    for (i = 0; i < 10; i = i + 1)
    begin
      tx(8'hC0 + i[7:0]);
      chk1("wr_ack", i < 9, ack);
    end
    i2c_host_i.cond(1'b1);
    sel(1'b1);
    // Drain with a stall cycle between words
    for (i = 0; i < 9; i = i + 1)
    begin
      for (j = 0; j < 20 && wr_valid !== 1'b1; j = j + 1)
        cyc(1);
      chk("wr_addr", {1'b0, 7'h7E + i[6:0]}, wr_addr);
      chk("wr_data", 8'hC0 + i[7:0], wr_data);
      wr_ready = 1'b1;
      cyc(1);
      wr_ready = 1'b0;
      cyc(1);
    end
    chk1("wr_empty", 1'b0, wr_valid);
    $display("test write done");
    rd_seq(8'h7E, 3);
    // Host abandons a read while the slave may hold the line low
    sel(1'b0);
    i2c_host_i.cond(1'b0);
    tx(8'hA1);
    i2c_host_i.recover;
    tx(8'hA0);
    chk1("recov_ack", 1'b1, ack);
    i2c_host_i.cond(1'b1);
    chk1("recov_amber", 1'b1, amber_led);
    sel(1'b1);
    rd_seq(8'h80, 1);
    $display("test read done");
    // Deselected, then a foreign address: no acknowledge, no write
    i2c_host_i.cond(1'b0);
    tx(8'hA0);
    chk1("desel_ack", 1'b0, ack);
    i2c_host_i.cond(1'b1);
    sel(1'b0);
    i2c_host_i.cond(1'b0);
    tx(8'hA2);
    chk1("addr_ack", 1'b0, ack);
    tx(8'h00);
    chk1("ignore_ack", 1'b0, ack);
    i2c_host_i.cond(1'b1);
    sel(1'b1);
    chk1("no_write", 1'b0, wr_valid);
    // Last read left the counter one past 0x80; ignored frames must not move it
    chk("rd_addr", 8'h81, rd_addr);
    $display("test ignore done");
    stop_test;
  end
endmodule
